// File: uwl_load_unit.sv
`timescale 1ns/100ps
module uwl_load_unit (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    issue_valid,
  input  wire logic [31:0]             issue_instr,
  input  wire logic [63:0]             base_value,
  input  wire logic [63:0]             target_value,
  input  wire uwl_pkg::uwl_fwd_t       fwd,
  input  wire logic                    mode_64,
  input  wire logic                    cpu_big_endian_flag,
  input  wire logic                    memory_big_endian_flag,
  input  wire logic                    user_endian_swap_flag,
  input  wire logic [3:0]              cop_usable,
  input  wire uwl_pkg::uwl_xlate_rsp_t xlate_rsp,
  input  wire uwl_pkg::uwl_mem_rsp_t   mem_rsp,
  output logic                         issue_ready,
  output uwl_pkg::uwl_xlate_req_t      xlate_req,
  output uwl_pkg::uwl_mem_req_t        mem_req,
  output uwl_pkg::uwl_wb_t             wb,
  output uwl_pkg::uwl_cop_t            cop,
  output uwl_pkg::uwl_exc_t            exc_code,
  output logic                         exc_valid
);
  import uwl_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_XLATE = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_WB    = 4'b1000
  } uwl_state_t;

  uwl_state_t  state;
  uwl_state_t  next_state;
  logic        is_cop;
  logic [1:0]  cop_num;
  logic [4:0]  target;
  logic [63:0] vaddr;
  logic [63:0] old_value;
  logic [63:0] mem_data;
  uwl_exc_t    pend_exc;

  logic [5:0]  dec_op;
  logic        dec_left;
  logic        dec_cop;
  logic [63:0] dec_vaddr;
  logic [1:0]  lane;
  logic [35:0] adj_paddr;
  logic [31:0] merged;

  // Sign-extends the offset and adds it to the base
  function automatic logic [63:0] eff_addr(input logic [63:0] base, input logic [15:0] offs,
                                           input logic wide);
    logic [63:0] sum;
    sum = base + {{48{offs[15]}}, offs};
    eff_addr = wide ? sum : {{32{sum[31]}}, sum[31:0]};
  endfunction

  assign dec_op    = issue_instr[OPCODE_MSB -: 6];
  assign dec_left  = (dec_op == OP_LEFT_LOAD); // RULE_01
  assign dec_cop   = (dec_op[5:2] == OP_COP_LOAD_HI);
  assign dec_vaddr = eff_addr(base_value, issue_instr[OFFSET_MSB -: 16], mode_64); // RULE_02
  assign issue_ready = (state == ST_IDLE);

  // Byte index within the word after CPU endian adjustment; also the access type of a left load
  assign lane = vaddr[1:0] ^ {2{cpu_big_endian_flag}}; // RULE_11

  // Physical low bits after user endian swap and, for a left load only, memory endian correction
  always_comb begin
    adj_paddr = xlate_rsp.paddr;
    if (is_cop) begin
      adj_paddr[2] = xlate_rsp.paddr[2] ^ user_endian_swap_flag;
    end else begin
      adj_paddr[2:0] = xlate_rsp.paddr[2:0] ^ {3{user_endian_swap_flag}};
      if (!memory_big_endian_flag) begin
        adj_paddr[1:0] = 2'h0; // RULE_12
      end
    end
  end

  // Merge: memory bytes from the addressed one up to the word edge go high
  always_comb begin
    logic [31:0] mword;
    logic        wsel;
    mword  = 32'h0000_0000;
    wsel   = vaddr[2] ^ cpu_big_endian_flag;
    mword  = wsel ? mem_data[63:32] : mem_data[31:0];
    merged = old_value[31:0]; // RULE_04
    for (int i = 0; i < 4; i++) begin
      if (32'(i) <= 32'(lane)) begin
        merged[31 - 8*i -: 8] = mword[8*(32'(lane) - i) +: 8]; // RULE_03
      end
    end
    // Lower bytes left untouched keep the old register value
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (issue_valid && (dec_left || dec_cop)) begin
          next_state = ST_XLATE;
        end
      end
      ST_XLATE: begin
        if (pend_exc != UWL_EXC_NONE) begin
          next_state = ST_WB;
        end else if (xlate_rsp.ack) begin
          // A failed translation must not wait for a memory answer that never comes
          if (xlate_rsp.tlb_miss || xlate_rsp.tlb_invalid || xlate_rsp.addr_error) begin
            next_state = ST_WB; // RULE_08
          end else begin
            next_state = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (mem_rsp.ack) begin
          next_state = ST_WB;
        end
      end
      ST_WB: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture the instruction; forwarding avoids a stale target value
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      is_cop    <= 1'b0;
      cop_num   <= 2'h0;
      target    <= 5'h00;
      vaddr     <= 64'h0000_0000_0000_0000;
      old_value <= 64'h0000_0000_0000_0000;
    end else if (state == ST_IDLE && issue_valid) begin
      is_cop    <= dec_cop;
      cop_num   <= dec_op[1:0];
      target    <= issue_instr[TARGET_MSB -: 5];
      vaddr     <= dec_vaddr;
      if (fwd.valid && fwd.target == issue_instr[TARGET_MSB -: 5]) begin
        old_value <= fwd.data; // RULE_06
      end else if (wb.valid && wb.target == issue_instr[TARGET_MSB -: 5]) begin
        old_value <= wb.data; // RULE_06
      end else begin
        old_value <= target_value;
      end
    end
  end

  // Exception gathering; the first one seen wins and stops the access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_exc <= UWL_EXC_NONE;
    end else if (state == ST_IDLE) begin
      pend_exc <= UWL_EXC_NONE;
      if (issue_valid && dec_cop) begin
        if (dec_op[1:0] == COP_SYSTEM) begin
          pend_exc <= UWL_EXC_RESERVED; // RULE_13
        end else if (!cop_usable[dec_op[1:0]]) begin
          pend_exc <= UWL_EXC_COP_UNUSE; // RULE_09
        end else if (dec_vaddr[1:0] != 2'h0) begin
          pend_exc <= UWL_EXC_ADDR_ERROR; // RULE_09
        end
      end
      // Left load never checks alignment here // RULE_07
    end else if (state == ST_XLATE && xlate_rsp.ack && pend_exc == UWL_EXC_NONE) begin
      if (xlate_rsp.tlb_miss) begin
        pend_exc <= UWL_EXC_TLB_MISS; // RULE_08
      end else if (xlate_rsp.tlb_invalid) begin
        pend_exc <= UWL_EXC_TLB_INVALID; // RULE_08
      end else if (xlate_rsp.addr_error) begin
        pend_exc <= UWL_EXC_ADDR_ERROR; // RULE_08
      end
    end else if (state == ST_LOAD && mem_rsp.ack && mem_rsp.bus_error) begin
      pend_exc <= UWL_EXC_BUS_ERROR; // RULE_08
    end
  end

  // Memory request held until answered; translation request too, but only raised for one cycle when a coprocessor exception is already pending
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xlate_req <= '0;
      mem_req   <= '0;
    end else begin
      xlate_req.valid <= (next_state == ST_XLATE) && !(state == ST_XLATE && xlate_rsp.ack);
      if (state == ST_IDLE) begin
        xlate_req.vaddr <= dec_vaddr;
      end
      if (state == ST_XLATE && xlate_rsp.ack && next_state == ST_LOAD && !xlate_rsp.tlb_miss
          && !xlate_rsp.tlb_invalid && !xlate_rsp.addr_error) begin
        mem_req.valid       <= 1'b1;
        mem_req.paddr       <= adj_paddr; // RULE_12
        mem_req.access_type <= is_cop ? TYPE_WORD : lane; // RULE_11
      end else if (mem_rsp.ack) begin
        mem_req.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_data <= 64'h0000_0000_0000_0000;
    end else if (state == ST_LOAD && mem_rsp.ack) begin
      mem_data <= mem_rsp.data;
    end
  end

  // Write-back: register or coprocessor updated only on a clean access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb        <= '0;
      cop       <= '0;
      exc_valid <= 1'b0;
      exc_code  <= UWL_EXC_NONE;
    end else begin
      wb.valid  <= 1'b0;
      cop.valid <= 1'b0;
      exc_valid <= 1'b0;
      if (state == ST_WB) begin
        if (pend_exc != UWL_EXC_NONE) begin
          exc_valid <= 1'b1; // RULE_08
          exc_code  <= pend_exc;
        end else if (is_cop) begin
          cop.valid     <= 1'b1; // RULE_10
          cop.cop_num   <= cop_num;
          cop.target    <= target;
          cop.byte_lane <= vaddr[2:0] ^ {cpu_big_endian_flag, 2'h0};
          cop.data      <= (vaddr[2] ^ cpu_big_endian_flag) ? mem_data[63:32] : mem_data[31:0];
        end else begin
          wb.valid  <= 1'b1; // RULE_14
          wb.target <= target;
          if (mode_64) begin
            wb.data <= {{32{merged[31]}}, merged}; // RULE_05
          end else begin
            wb.data <= {old_value[63:32], merged};
          end
        end
      end
    end
  end

endmodule // uwl_load_unit

// File: uwl_load_unit_asserts.sv
`timescale 1ns/100ps
module uwl_load_unit_chk (
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    issue_valid,
  input wire logic [31:0]             issue_instr,
  input wire logic [63:0]             base_value,
  input wire logic                    mode_64,
  input wire logic                    cpu_big_endian_flag,
  input wire logic                    memory_big_endian_flag,
  input wire logic                    issue_ready,
  input wire uwl_pkg::uwl_xlate_req_t xlate_req,
  input wire uwl_pkg::uwl_xlate_rsp_t xlate_rsp,
  input wire uwl_pkg::uwl_mem_req_t   mem_req,
  input wire uwl_pkg::uwl_mem_rsp_t   mem_rsp,
  input wire uwl_pkg::uwl_wb_t        wb,
  input wire uwl_pkg::uwl_cop_t       cop,
  input wire logic                    exc_valid
);
  import uwl_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       lft;
  logic [2:0] va;
  // Remember the kind of operation so the address checks only fire for the left load
  always_ff @(posedge sys_clk) begin
    if (reset) lft <= 1'b0;
    else if (issue_valid && issue_ready) lft <= issue_instr[31:26] == OP_LEFT_LOAD;
  end
  always_ff @(posedge sys_clk) begin
    if (xlate_req.valid) va <= xlate_req.vaddr[2:0];
  end
  a_addr_form: assert property (
    issue_valid && issue_ready && mode_64 && issue_instr[31:26] == OP_LEFT_LOAD |=> xlate_req.valid
    && xlate_req.vaddr == $past(base_value) + {{48{$past(issue_instr[15])}}, $past(issue_instr[15:0])})
    else $error("address sum wrong");
  a_no_align: assert property (lft && xlate_req.valid && xlate_rsp.ack && !xlate_rsp.tlb_miss
    && !xlate_rsp.tlb_invalid && !xlate_rsp.addr_error |-> ##[1:2] mem_req.valid)
    else $error("left load stopped after clean translation");
  a_type_le: assert property (lft && mem_req.valid && !cpu_big_endian_flag
    |-> mem_req.access_type == va[1:0]) else $error("access type wrong, little cpu");
  a_type_be: assert property (lft && mem_req.valid && cpu_big_endian_flag
    |-> mem_req.access_type == ~va[1:0]) else $error("access type wrong, big cpu");
  a_mem_clear: assert property (lft && mem_req.valid && !memory_big_endian_flag
    |-> mem_req.paddr[1:0] == 2'h0) else $error("low address bits not cleared");
  a_sign_fill: assert property (lft && wb.valid && mode_64
    |-> wb.data[63:32] == {32{wb.data[31]}}) else $error("upper half not sign fill");
  a_wb_done: assert property (lft && mem_req.valid && mem_rsp.ack && !mem_rsp.bus_error
    |-> ##[1:3] wb.valid) else $error("write-back missing");
  a_bus_abort: assert property (lft && mem_req.valid && mem_rsp.ack && mem_rsp.bus_error
    |-> ##[1:3] (exc_valid && !wb.valid)) else $error("bus error did not abort");
  a_cop_zero: assert property (cop.valid |-> cop.cop_num != COP_SYSTEM)
    else $error("coprocessor zero accepted");
endmodule // uwl_load_unit_chk
bind uwl_load_unit uwl_load_unit_chk i_uwl_load_unit_chk (.sys_clk, .reset, .issue_valid,
  .issue_instr, .base_value, .mode_64, .cpu_big_endian_flag, .memory_big_endian_flag,
  .issue_ready, .xlate_req, .xlate_rsp, .mem_req, .mem_rsp, .wb, .cop, .exc_valid);

// File: uwl_load_unit_tb.sv
`timescale 1ns/100ps
module uwl_load_unit_tb;
  import uwl_pkg::*;
  localparam logic [63:0] MEM_DATA = 64'h1122_3344_ccdd_eeff;
  localparam logic [63:0] OLD      = 64'h5566_7788_99aa_bbcc;
  logic sys_clk, reset, issue_valid, mode_64, issue_ready, exc_valid, tlb_miss_en, bus_err_en;
  logic cpu_big_endian_flag, memory_big_endian_flag, user_endian_swap_flag, gw, ge, gc;
  logic [31:0]    issue_instr;
  logic [63:0]    base_value, target_value, wbd;
  logic [3:0]     cop_usable;
  logic [4:0]     wbt;
  logic [2:0]     mp;
  logic [1:0]     mt;
  uwl_fwd_t       fwd;
  uwl_xlate_req_t xlate_req;
  uwl_xlate_rsp_t xlate_rsp;
  uwl_mem_req_t   mem_req;
  uwl_mem_rsp_t   mem_rsp;
  uwl_wb_t        wb;
  uwl_cop_t       cop, cr;
  uwl_exc_t       exc_code, ec;
  int             miscompares = 0, tests_run = 0, cycles = 0;

  uwl_load_unit i_uwl_load_unit (.sys_clk, .reset, .issue_valid, .issue_instr, .base_value,
    .target_value, .fwd, .mode_64, .cpu_big_endian_flag, .memory_big_endian_flag,
    .user_endian_swap_flag, .cop_usable, .xlate_rsp, .mem_rsp, .issue_ready, .xlate_req,
    .mem_req, .wb, .cop, .exc_code, .exc_valid);
  uwl_mem_model i_uwl_mem_model (.sys_clk, .reset, .xlate_req, .mem_req, .tlb_miss_en,
    .bus_err_en, .xlate_rsp, .mem_rsp);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for idle so a request is never offered while the unit is busy
  task automatic run(input logic [31:0] ins, input logic [63:0] bs);
    @(negedge sys_clk);
    while (issue_ready !== 1'b1) @(negedge sys_clk);
    issue_valid = 1'b1;
    issue_instr = ins;
    base_value = bs;
    @(negedge sys_clk);
    issue_valid = 1'b0;
    {gw, ge, gc} = 3'h0;
    for (int n = 0; n < 20 && !(gw || ge || gc); n++) begin
      @(posedge sys_clk);
      #1;
      if (mem_req.valid) {mt, mp} = {mem_req.access_type, mem_req.paddr[2:0]};
      if (wb.valid) {gw, wbd, wbt} = {1'b1, wb.data, wb.target};
      if (exc_valid) begin
        ge = 1'b1;
        ec = exc_code;
      end
      if (cop.valid) {gc, cr} = {1'b1, cop};
    end
    // Hold inputs until the result pulse has gone, so no flag moves under it
    // and the next issue does not pick up this result as forwarded data
    repeat (2) @(negedge sys_clk);
  endtask
  function automatic logic [63:0] lwl_exp(input logic [2:0] va, input logic cbe, input logic m64,
                                          input logic [63:0] old);
    logic [1:0]  b;
    logic [31:0] wd, t;
    b = va[1:0] ^ {2{cbe}};
    wd = (va[2] ^ cbe) ? MEM_DATA[63:32] : MEM_DATA[31:0];
    t = (wd << (24 - 8 * b)) | (old[31:0] & (32'h00ff_ffff >> (8 * b)));
    return {m64 ? {32{t[31]}} : old[63:32], t};
  endfunction

  task automatic t_left;
    for (int i = 0; i < 16; i++) begin
      {cpu_big_endian_flag, user_endian_swap_flag, mode_64} = {i[3], i[2], i[1]};
      memory_big_endian_flag = i[0] ^ i[3];
      run({OP_LEFT_LOAD, 5'd3, 5'd4, 16'hfff8}, 64'h1008 + i[2:0]);
      chk(gw, 1'b1);
      chk(ge, 1'b0);
      chk(wbt, 5'd4);
      chk(wbd, lwl_exp(i[2:0], i[3], i[1], OLD));
      chk(mt, i[1:0] ^ {2{i[3]}});
      chk(mp, (i[2:0] ^ {3{i[2]}}) & ((i[0] ^ i[3]) ? 3'h7 : 3'h4));
    end
  endtask
  task automatic t_fwd;
    {cpu_big_endian_flag, memory_big_endian_flag, user_endian_swap_flag, mode_64} = 4'h1;
    fwd = '{1'b1, 5'd4, 64'h0123_4567_89ab_cdef};
    run({OP_LEFT_LOAD, 5'd3, 5'd4, 16'h0000}, 64'h1001);
    chk(wbd, lwl_exp(3'h1, 1'b0, 1'b1, fwd.data));
    fwd.valid = 1'b0;
  endtask
  task automatic t_err;
    for (int k = 0; k < 2; k++) begin
      {tlb_miss_en, bus_err_en} = {k == 0, k == 1};
      run({OP_LEFT_LOAD, 5'd3, 5'd4, 16'h0000}, 64'h1002);
      chk(gw, 1'b0);
      chk(ec, k ? UWL_EXC_BUS_ERROR : UWL_EXC_TLB_MISS);
    end
    {tlb_miss_en, bus_err_en} = 2'h0;
  endtask
  task automatic t_cop;
    for (int k = 0; k < 3; k++) begin
      run({OP_COP_LOAD_HI, 2'(k == 0 ? 1 : (k == 1 ? 2 : 0)), 5'd3, 5'd7, 16'h0000}, 64'h1004);
      if (k == 0) begin
        chk(gc, 1'b1);
        chk(mt, TYPE_WORD);
        chk(cr.data, MEM_DATA[63:32]);
        chk({cr.byte_lane, cr.target}, {3'h4, 5'd7});
      end else begin
        chk(ec, k == 1 ? UWL_EXC_COP_UNUSE : UWL_EXC_RESERVED);
      end
    end
  endtask

  initial begin
    {reset, issue_valid, mode_64, tlb_miss_en, bus_err_en} = 5'h10;
    {cpu_big_endian_flag, memory_big_endian_flag, user_endian_swap_flag} = 3'h0;
    {issue_instr, base_value, target_value, fwd} = {32'h0, 64'h0, OLD, 70'h0};
    cop_usable = 4'h2;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    t_left;
    t_fwd;
    t_err;
    t_cop;
    results;
  end
endmodule // uwl_load_unit_tb

// File: uwl_mem_model.sv
`timescale 1ns/100ps
module uwl_mem_model (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire uwl_pkg::uwl_xlate_req_t xlate_req,
  input  wire uwl_pkg::uwl_mem_req_t   mem_req,
  input  wire logic                    tlb_miss_en,
  input  wire logic                    bus_err_en,
  output uwl_pkg::uwl_xlate_rsp_t      xlate_rsp,
  output uwl_pkg::uwl_mem_rsp_t        mem_rsp
);
  import uwl_pkg::*;
  localparam logic [63:0] MEM_DATA = 64'h1122_3344_ccdd_eeff;
  // Identity mapping keeps the expected physical bits easy to derive
  always_ff @(posedge sys_clk) begin
    if (reset) xlate_rsp <= '0;
    else xlate_rsp <= '{xlate_req.valid && !xlate_rsp.ack, xlate_req.vaddr[35:0],
                        tlb_miss_en, 1'b0, 1'b0};
  end
  // Idle data toggles so a late sample never passes by chance
  always_ff @(posedge sys_clk) begin
    if (reset) mem_rsp <= '0;
    else mem_rsp <= '{mem_req.valid && !mem_rsp.ack,
                      (mem_req.valid && !mem_rsp.ack) ? MEM_DATA : ~mem_rsp.data, bus_err_en};
  end
endmodule // uwl_mem_model

// File: uwl_pkg.sv
// How it works
// RULE_01 - Opcode 100010 selects left load; base, target, offset fields at fixed positions
// RULE_02 - Address is base plus sign-extended 16-bit offset; any byte alignment allowed
// RULE_03 - Addressed byte lands in top byte, following bytes fill lower positions
// RULE_04 - Low bytes that get no memory byte keep old register contents
// RULE_05 - In 64-bit mode upper 32 bits copy bit 31 of merged word
// RULE_06 - Old target value comes forwarded from an immediately preceding load
// RULE_07 - Unaligned address alone never raises address error for left load
// RULE_08 - TLB miss, TLB invalid, bus and address errors abort the update
// RULE_09 - Coprocessor load reports memory errors plus coprocessor unusable
// RULE_10 - Coprocessor load passes word, target number and byte lane to coprocessor
// RULE_11 - Access type is low address bits, or three minus them for big-endian CPU
// RULE_12 - Little-endian memory clears low two physical bits; big-endian keeps three
// RULE_13 - Coprocessor load naming coprocessor zero is not valid
// RULE_14 - Target write happens in write-back only when no exception occurred
package uwl_pkg;

  localparam logic [5:0] OP_LEFT_LOAD   = 6'h22;
  localparam logic [3:0] OP_COP_LOAD_HI = 4'hc;
  localparam int         OPCODE_MSB     = 31;
  localparam int         BASE_MSB       = 25;
  localparam int         TARGET_MSB     = 20;
  localparam int         OFFSET_MSB     = 15;
  localparam logic [1:0] TYPE_WORD      = 2'h3;
  localparam logic [1:0] COP_SYSTEM     = 2'h0;

  typedef enum logic [2:0] {
    UWL_EXC_NONE        = 3'h0,
    UWL_EXC_TLB_MISS    = 3'h1,
    UWL_EXC_TLB_INVALID = 3'h2,
    UWL_EXC_BUS_ERROR   = 3'h3,
    UWL_EXC_ADDR_ERROR  = 3'h4,
    UWL_EXC_COP_UNUSE   = 3'h5,
    UWL_EXC_RESERVED    = 3'h6
  } uwl_exc_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  target;
    logic [63:0] data;
  } uwl_fwd_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] vaddr;
  } uwl_xlate_req_t;

  typedef struct packed {
    logic        ack;
    logic [35:0] paddr;
    logic        tlb_miss;
    logic        tlb_invalid;
    logic        addr_error;
  } uwl_xlate_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [35:0] paddr;
    logic [1:0]  access_type;
  } uwl_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [63:0] data;
    logic        bus_error;
  } uwl_mem_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  target;
    logic [63:0] data;
  } uwl_wb_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  cop_num;
    logic [4:0]  target;
    logic [2:0]  byte_lane;
    logic [31:0] data;
  } uwl_cop_t;

endpackage
